// ---- core/ditd_cfg.svh ----
// constants of the input terminal decoder: timing, ranges and reset values
`ifndef DITD_CFG_SVH
`define DITD_CFG_SVH

// ============================================================
// timing
`define DITD_CLK_PERIOD_NS   8
`define DITD_SCAN_STEP_NS    100000
`define DITD_STEPS_PER_MS    4'd10

// ============================================================
// scan period setting, in scan steps
`define DITD_SCAN_MIN        11'd10
`define DITD_SCAN_MAX        11'd2000
`define DITD_SCAN_DEFAULT    11'd10

// ============================================================
// master speed ramp
`define DITD_RAMP_MIN_DS     16'd200
`define DITD_DS_TO_MS        24'd100
`define DITD_SPEED_FULL      16'd1000
`define DITD_SPEED_RESET     16'h0000
`define DITD_FREQ_SRC_UPDOWN 4'h8

`endif

// ---- core/ditd_pkg.sv ----
// types shared by the input terminal decoder
package ditd_pkg;

	// terminal function codes
	typedef enum logic [3:0] {
		FN_OFF = 4'h0, FN_EXT_FAULT = 4'h1, FN_FAULT_RESET = 4'h2,
		FN_COAST = 4'h3, FN_SPEED_UP = 4'h4, FN_SPEED_DOWN = 4'h5,
		FN_STAGE0 = 4'h6, FN_STAGE1 = 4'h7, FN_STAGE2 = 4'h8,
		FN_STAGE3 = 4'h9, FN_JOG = 4'ha, FN_AUTO = 4'hb,
		FN_AUTO_PAUSE = 4'hc, FN_PID = 4'hd, FN_FORCE_AI1 = 4'he,
		FN_SERIAL = 4'hf
	} ditd_func_t;

	// run wiring schemes of the first terminals
	typedef enum logic [1:0] {
		WIRE_TWO_DIR = 2'h0, WIRE_RUN_DIR = 2'h1, WIRE_THREE = 2'h2
	} ditd_wiring_t;

	// winning speed source, one-hot
	typedef enum logic [4:0] {
		SRC_CONFIG = 5'h01, SRC_STAGE = 5'h02, SRC_AI1 = 5'h04,
		SRC_JOG = 5'h08, SRC_AUTO = 5'h10
	} ditd_src_t;

	typedef struct packed {
		logic run;
		logic reverse;
		logic driveOn;
	} ditd_run_t;

	typedef struct packed {
		logic jog;
		logic autoRun;
		logic autoPause;
		logic pidEnable;
		logic forceAi1;
		logic serialBus;
	} ditd_aux_t;

endpackage

// ---- core/ditd_filter.sv ----
// terminal synchroniser and scan-rate bounce filter
`timescale 1ns/1ns
`default_nettype none

module ditd_filter
	import ditd_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [7:0] pinIn,
	input  wire logic       scanTick,
	output var  logic [7:0] levelOut
);

	logic [7:0] syncA_reg;
	logic [7:0] syncB_reg;
	logic [7:0] sample_reg;
	logic [7:0] sample_next;
	logic [7:0] level_next;

	// ============================================================
	// two-stage synchroniser, first stage read only by the second
	always_ff @(posedge clk) begin
		if (!nrst) begin
			syncA_reg <= 8'h00;
			syncB_reg <= 8'h00;
		end else begin
			syncA_reg <= pinIn;
			syncB_reg <= syncA_reg;
		end
	end

	// ============================================================
	// a level is taken only if two scans in a row agree
	always_comb begin
		sample_next = sample_reg;
		level_next  = levelOut;
		if (scanTick) begin
			sample_next = syncB_reg;
			level_next  = (syncB_reg & sample_reg) |
				(levelOut & (syncB_reg | sample_reg));
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sample_reg <= 8'h00;
			levelOut   <= 8'h00;
		end else begin
			sample_reg <= sample_next;
			levelOut   <= level_next;
		end
	end

	// ============================================================
	// checks
	property p_level_on_scan;
		@(posedge clk) disable iff (!nrst)
		!scanTick |=> $stable(levelOut);
	endproperty
	a_level_on_scan: assert property (p_level_on_scan)
		else $error("terminal level moved between scans");

	property p_agree_taken;
		@(posedge clk) disable iff (!nrst)
		(scanTick && syncB_reg == sample_reg) |=> levelOut == $past(syncB_reg);
	endproperty
	a_agree_taken: assert property (p_agree_taken)
		else $error("agreeing scans not taken");

endmodule

`default_nettype wire

// ---- core/ditd_decoder.sv ----
// digital input terminal decoder: filtering, run wiring, terminal functions
//
// Summary of operation
// - scan period 10..2000 steps, reset value 10
// - scan interval is setting times 0.1 ms
// - mode 0: term1 forward, term2 reverse
// - mode 1: term1 run, term2 direction
// - mode 2: push run latches, stop opens
// - three-wire: term3 selects direction
// - three-wire: term3 function code ignored
// - terminals 1 and 2 carry no functions
// - codes 0..14 on 3..7, 0..15 on 8
// - code 0 terminal fully ignored
// - code 1 trips fault, output off
// - code 2 clears latched fault
// - code 3 coasts: output off at once
// - code 4 raises speed, ramp min 20 s
// - code 5 lowers speed, ramp min 20 s
// - up/down only with frequency source 8
// - codes 6..9 form 4-bit stage index
// - auto, jog, ai1, stage, configured source
// - code 15 only on terminal eight
`timescale 1ns/1ns
`default_nettype none
`include "ditd_cfg.svh"

module ditd_decoder
	import ditd_pkg::*;
#(
	parameter int STEP_CYCLES = (`DITD_SCAN_STEP_NS + `DITD_CLK_PERIOD_NS - 1)
		/ `DITD_CLK_PERIOD_NS
)(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [8:1] inputTerminal,
	input  wire logic       scanPeriodLoad,
	input  wire logic [10:0] inputScanPeriod,
	input  wire logic [1:0] runWiringMode,
	input  wire logic [3:0] term3FunctionCode,
	input  wire logic [3:0] term4FunctionCode,
	input  wire logic [3:0] term5FunctionCode,
	input  wire logic [3:0] term6FunctionCode,
	input  wire logic [3:0] term7FunctionCode,
	input  wire logic [3:0] term8FunctionCode,
	input  wire logic [15:0] accelTimeSetting,
	input  wire logic [15:0] decelTimeSetting,
	input  wire logic [3:0] freqCommandSource,
	output var  logic [10:0] scanPeriodNow,
	output var  logic [8:1] filteredTerminal,
	output var  ditd_run_t  runState,
	output var  logic       faultTripped,
	output var  logic       coastStop,
	output var  logic [3:0] stageIndex,
	output var  ditd_src_t  speedSource,
	output var  logic [15:0] masterSpeed,
	output var  ditd_aux_t  auxFunc
);

	localparam logic [13:0] STEP_LAST = 14'(STEP_CYCLES - 1);

	// does any enabled terminal with this code stand closed
	function automatic logic funcHit(input logic [3:0] code,
		input logic [5:0][3:0] cds, input logic [5:0] lv);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 6; i++) begin
			if (cds[i] == code && lv[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// ============================================================
	// scan timing: 0.1 ms steps, scan ticks and millisecond ticks
	logic [13:0] stepCnt_reg, stepCnt_next;
	logic [10:0] scanCnt_reg, scanCnt_next;
	logic [3:0]  msCnt_reg, msCnt_next;
	logic        scanTick_reg, scanTick_next;
	logic        msTick_reg, msTick_next;
	logic [10:0] scanPeriod_next;
	logic        stepTick;

	always_comb begin
		stepTick        = (stepCnt_reg == STEP_LAST);
		stepCnt_next    = stepTick ? 14'h0000 : stepCnt_reg + 14'h0001;
		scanCnt_next    = scanCnt_reg;
		msCnt_next      = msCnt_reg;
		scanTick_next   = 1'b0;
		msTick_next     = 1'b0;
		scanPeriod_next = scanPeriodNow;
		// out-of-range settings are refused, the old one stays
		if (scanPeriodLoad && inputScanPeriod >= `DITD_SCAN_MIN &&
			inputScanPeriod <= `DITD_SCAN_MAX) begin
			scanPeriod_next = inputScanPeriod;
		end
		if (stepTick) begin
			if (scanCnt_reg + 11'h001 >= scanPeriodNow) begin
				scanCnt_next  = 11'h000;
				scanTick_next = 1'b1;
			end else begin
				scanCnt_next = scanCnt_reg + 11'h001;
			end
			if (msCnt_reg == `DITD_STEPS_PER_MS - 4'd1) begin
				msCnt_next  = 4'h0;
				msTick_next = 1'b1;
			end else begin
				msCnt_next = msCnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stepCnt_reg   <= 14'h0000;
			scanCnt_reg   <= 11'h000;
			msCnt_reg     <= 4'h0;
			scanTick_reg  <= 1'b0;
			msTick_reg    <= 1'b0;
			scanPeriodNow <= `DITD_SCAN_DEFAULT;
		end else begin
			stepCnt_reg   <= stepCnt_next;
			scanCnt_reg   <= scanCnt_next;
			msCnt_reg     <= msCnt_next;
			scanTick_reg  <= scanTick_next;
			msTick_reg    <= msTick_next;
			scanPeriodNow <= scanPeriod_next;
		end
	end

	// ============================================================
	// filtered terminal levels
	ditd_filter u_filter (
		.clk      (clk),
		.nrst     (nrst),
		.pinIn    (inputTerminal),
		.scanTick (scanTick_reg),
		.levelOut (filteredTerminal)
	);

	// ============================================================
	// multifunction decode over terminals 3..8
	logic [5:0][3:0] codes;
	logic [5:0]      live;
	logic extFault, faultReset, coastAct, spdUp, spdDown;

	always_comb begin
		codes = {term8FunctionCode, term7FunctionCode, term6FunctionCode,
			term5FunctionCode, term4FunctionCode, term3FunctionCode};
		live  = filteredTerminal[8:3];
		if (runWiringMode == WIRE_THREE) begin
			live[0] = 1'b0;
		end
		// code 15 exists only on terminal eight
		for (int i = 0; i < 5; i++) begin
			if (codes[i] == FN_SERIAL) begin
				live[i] = 1'b0;
			end
		end
		// code 0 is never looked up, so such a terminal does nothing
		extFault   = funcHit(FN_EXT_FAULT, codes, live);
		faultReset = funcHit(FN_FAULT_RESET, codes, live);
		coastAct   = funcHit(FN_COAST, codes, live);
		spdUp      = funcHit(FN_SPEED_UP, codes, live);
		spdDown    = funcHit(FN_SPEED_DOWN, codes, live);
	end

	// ============================================================
	// fault latch, coast and run commands
	logic      runLatch_reg, runLatch_next;
	logic      fault_next;
	ditd_run_t run_next;
	logic      t1, t2, t3;

	always_comb begin
		t1 = filteredTerminal[1];
		t2 = filteredTerminal[2];
		t3 = filteredTerminal[3];
		// a fault still present wins over a reset
		if (extFault) begin
			fault_next = 1'b1;
		end else if (faultReset) begin
			fault_next = 1'b0;
		end else begin
			fault_next = faultTripped;
		end
		runLatch_next = 1'b0;
		if (runWiringMode == WIRE_THREE && t2 && !fault_next && !coastAct) begin
			runLatch_next = runLatch_reg | t1;
		end
		run_next = '0;
		case (runWiringMode)
			WIRE_TWO_DIR: begin
				// both closed is read as stop
				run_next.run     = t1 ^ t2;
				run_next.reverse = t2 & !t1;
			end
			WIRE_RUN_DIR: begin
				run_next.run     = t1;
				run_next.reverse = t2;
			end
			WIRE_THREE: begin
				run_next.run     = runLatch_next;
				run_next.reverse = t3;
			end
			default: begin
				run_next = '0;
			end
		endcase
		run_next.driveOn = run_next.run && !fault_next && !coastAct;
		run_next.run     = run_next.driveOn;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			runLatch_reg <= 1'b0;
			faultTripped <= 1'b0;
			coastStop    <= 1'b0;
			runState     <= '0;
		end else begin
			runLatch_reg <= runLatch_next;
			faultTripped <= fault_next;
			coastStop    <= coastAct;
			runState     <= run_next;
		end
	end

	// ============================================================
	// speed selection and master speed ramp
	logic [23:0] rampMs;
	logic [23:0] acc_reg, acc_next, accSum;
	logic [15:0] speed_next;
	logic [3:0]  stage_next;
	ditd_src_t   src_next;
	ditd_aux_t   aux_next;
	logic        rampEn, goUp;

	always_comb begin
		stage_next = {funcHit(FN_STAGE3, codes, live),
			funcHit(FN_STAGE2, codes, live),
			funcHit(FN_STAGE1, codes, live),
			funcHit(FN_STAGE0, codes, live)};
		aux_next.jog       = funcHit(FN_JOG, codes, live);
		aux_next.autoRun   = funcHit(FN_AUTO, codes, live);
		aux_next.autoPause = funcHit(FN_AUTO_PAUSE, codes, live);
		aux_next.pidEnable = funcHit(FN_PID, codes, live);
		aux_next.forceAi1  = funcHit(FN_FORCE_AI1, codes, live);
		aux_next.serialBus = funcHit(FN_SERIAL, codes, live);
		// stage 0 is the master speed, so it falls to the set source
		if (aux_next.autoRun) begin
			src_next = SRC_AUTO;
		end else if (aux_next.jog) begin
			src_next = SRC_JOG;
		end else if (aux_next.forceAi1) begin
			src_next = SRC_AI1;
		end else if (stage_next != 4'h0) begin
			src_next = SRC_STAGE;
		end else begin
			src_next = SRC_CONFIG;
		end
		goUp = spdUp;
		if (spdUp) begin
			rampMs = {8'h00, (accelTimeSetting < `DITD_RAMP_MIN_DS) ?
				`DITD_RAMP_MIN_DS : accelTimeSetting} * `DITD_DS_TO_MS;
		end else begin
			rampMs = {8'h00, (decelTimeSetting < `DITD_RAMP_MIN_DS) ?
				`DITD_RAMP_MIN_DS : decelTimeSetting} * `DITD_DS_TO_MS;
		end
		// both held at once is a hold, not a fight
		rampEn = (freqCommandSource == `DITD_FREQ_SRC_UPDOWN) &&
			(spdUp ^ spdDown);
		accSum     = acc_reg + {8'h00, `DITD_SPEED_FULL};
		acc_next   = acc_reg;
		speed_next = masterSpeed;
		// ramp floor of 20 s keeps this to one step per millisecond
		if (rampEn && msTick_reg) begin
			if (accSum >= rampMs) begin
				acc_next = accSum - rampMs;
				if (goUp && masterSpeed < `DITD_SPEED_FULL) begin
					speed_next = masterSpeed + 16'h0001;
				end else if (!goUp && masterSpeed != 16'h0000) begin
					speed_next = masterSpeed - 16'h0001;
				end
			end else begin
				acc_next = accSum;
			end
		end else if (!rampEn) begin
			acc_next = 24'h000000;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			acc_reg     <= 24'h000000;
			masterSpeed <= `DITD_SPEED_RESET;
			stageIndex  <= 4'h0;
			speedSource <= SRC_CONFIG;
			auxFunc     <= '0;
		end else begin
			acc_reg     <= acc_next;
			masterSpeed <= speed_next;
			stageIndex  <= stage_next;
			speedSource <= src_next;
			auxFunc     <= aux_next;
		end
	end

	// ============================================================
	// checks
	property p_scan_range;
		@(posedge clk) disable iff (!nrst)
		scanPeriodNow >= `DITD_SCAN_MIN && scanPeriodNow <= `DITD_SCAN_MAX;
	endproperty
	a_scan_range: assert property (p_scan_range)
		else $error("scan period out of range");

	property p_fault_trip;
		@(posedge clk) disable iff (!nrst)
		extFault |=> faultTripped && !runState.driveOn;
	endproperty
	a_fault_trip: assert property (p_fault_trip)
		else $error("external fault did not trip");

	property p_fault_clear;
		@(posedge clk) disable iff (!nrst)
		(faultTripped && faultReset && !extFault) |=> !faultTripped;
	endproperty
	a_fault_clear: assert property (p_fault_clear)
		else $error("fault reset did not clear");

	property p_coast_off;
		@(posedge clk) disable iff (!nrst)
		coastAct |=> coastStop && !runState.driveOn && !runState.run;
	endproperty
	a_coast_off: assert property (p_coast_off)
		else $error("coast did not cut output");

	property p_two_wire_fwd;
		@(posedge clk) disable iff (!nrst)
		(runWiringMode == WIRE_TWO_DIR && t1 && !t2 && !extFault &&
			!faultTripped && !coastAct) |=> runState.run && !runState.reverse;
	endproperty
	a_two_wire_fwd: assert property (p_two_wire_fwd)
		else $error("two-wire forward not run");

	sequence s_push_run;
		runWiringMode == WIRE_THREE && t1 && t2 && !extFault &&
			!faultTripped && !coastAct;
	endsequence
	sequence s_stop_open;
		runWiringMode == WIRE_THREE && !t2;
	endsequence
	property p_three_wire;
		@(posedge clk) disable iff (!nrst)
		s_push_run ##1 (runWiringMode == WIRE_THREE && t2 && !t1 &&
			!extFault && !coastAct) |=> runState.run and (s_stop_open |=> !runState.run);
	endproperty
	a_three_wire: assert property (p_three_wire)
		else $error("three-wire latch misbehaved");

	property p_auto_first;
		@(posedge clk) disable iff (!nrst)
		funcHit(FN_AUTO, codes, live) |=> speedSource == SRC_AUTO;
	endproperty
	a_auto_first: assert property (p_auto_first)
		else $error("auto operation not first");

	property p_updown_gate;
		@(posedge clk) disable iff (!nrst)
		freqCommandSource != `DITD_FREQ_SRC_UPDOWN |=> $stable(masterSpeed);
	endproperty
	a_updown_gate: assert property (p_updown_gate)
		else $error("master speed moved without up/down source");

endmodule

`default_nettype wire

// ---- tb/ditd_switch_model.sv ----
// switch and push-button model wired to the input terminals
`timescale 1ns/1ns
`default_nettype none

module ditd_switch_model
	import ditd_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [8:1] closeCmd,
	input  wire logic       bounceEn,
	output var  logic [8:1] pins
);
	logic [8:1] oldLevel;
	logic [8:1] newLevel;
	logic [2:0] bounceCnt;

	initial begin
		oldLevel = 8'h00;
		newLevel = 8'h00;
		bounceCnt = 3'h0;
	end

	// contacts chatter between old and new level for a few clocks
	always @(posedge clk) begin
		if (closeCmd !== newLevel) begin
			oldLevel <= newLevel;
			newLevel <= closeCmd;
			bounceCnt <= bounceEn ? 3'h6 : 3'h0;
		end else if (bounceCnt != 3'h0) begin
			bounceCnt <= bounceCnt - 3'h1;
		end
	end

	// odd counts show the old level: far shorter than a scan interval
	assign pins = bounceCnt[0] ? oldLevel : newLevel;
endmodule

`default_nettype wire

// ---- tb/drive_input_terminal_decoder_bench.sv ----
// self-checking bench of the input terminal decoder
`timescale 1ns/1ns
`default_nettype none

module drive_input_terminal_decoder_bench
	import ditd_pkg::*;
;
	logic        clk, nrst, scanPeriodLoad, bounceEn;
	logic [8:1]  termCmd, pins, filteredTerminal;
	logic [10:0] inputScanPeriod, scanPeriodNow;
	logic [1:0]  runWiringMode;
	logic [3:0]  fc3, fc4, fc5, fc6, fc7, fc8, freqSrc, stageIndex;
	logic [15:0] accelTime, decelTime, masterSpeed;
	logic        faultTripped, coastStop;
	ditd_run_t   runState;
	ditd_src_t   speedSource;
	ditd_aux_t   auxFunc;
	int          fail_count, checked;

	// short scan step keeps every filter wait to a few dozen clocks
	ditd_decoder #(.STEP_CYCLES(2)) uut (.clk(clk), .nrst(nrst),
		.inputTerminal(pins), .scanPeriodLoad(scanPeriodLoad),
		.inputScanPeriod(inputScanPeriod), .runWiringMode(runWiringMode),
		.term3FunctionCode(fc3), .term4FunctionCode(fc4),
		.term5FunctionCode(fc5), .term6FunctionCode(fc6),
		.term7FunctionCode(fc7), .term8FunctionCode(fc8),
		.accelTimeSetting(accelTime), .decelTimeSetting(decelTime),
		.freqCommandSource(freqSrc), .scanPeriodNow(scanPeriodNow),
		.filteredTerminal(filteredTerminal), .runState(runState),
		.faultTripped(faultTripped), .coastStop(coastStop),
		.stageIndex(stageIndex), .speedSource(speedSource),
		.masterSpeed(masterSpeed), .auxFunc(auxFunc));

	ditd_switch_model sw (.clk(clk), .closeCmd(termCmd),
		.bounceEn(bounceEn), .pins(pins));

	// ============================================================
	// helpers
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// two ticks of 20 clocks plus sync, bounce and decode margin
	task automatic setT(input logic [8:1] v);
		@(posedge clk);
		termCmd <= v;
		cyc(70);
	endtask

	function automatic logic [15:0] rr();
		return {14'h0, runState.run, runState.reverse};
	endfunction

	task automatic load(input logic [10:0] v);
		@(posedge clk);
		scanPeriodLoad <= 1'b1;
		inputScanPeriod <= v;
		@(posedge clk);
		scanPeriodLoad <= 1'b0;
		cyc(1);
	endtask

	task automatic give_verdict();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ============================================================
	// scenarios
	task automatic t_scan();
		chk(scanPeriodNow, 16'd10);
		chk(speedSource, 16'h01);
		load(11'd9);
		chk(scanPeriodNow, 16'd10);
		load(11'd2001);
		chk(scanPeriodNow, 16'd10);
		load(11'd2000);
		chk(scanPeriodNow, 16'd2000);
		load(11'd20);
		@(posedge clk);
		termCmd <= 8'h04;
		cyc(40);
		chk(filteredTerminal, 16'h00);
		cyc(60);
		chk(filteredTerminal, 16'h04);
		load(11'd10);
		setT(8'h00);
		// a pulse far shorter than one scan interval
		termCmd <= 8'h04;
		cyc(3);
		setT(8'h00);
		chk(filteredTerminal, 16'h00);
	endtask

	task automatic t_two_wire();
		runWiringMode <= WIRE_TWO_DIR;
		setT(8'h01);
		chk(rr(), 16'h2);
		setT(8'h02);
		chk(rr(), 16'h3);
		setT(8'h00);
		chk(rr(), 16'h0);
		// the unused wiring code must never run the drive
		runWiringMode <= 2'h3;
		setT(8'h01);
		chk(rr(), 16'h0);
		runWiringMode <= WIRE_RUN_DIR;
		setT(8'h01);
		chk(rr(), 16'h2);
		setT(8'h03);
		chk(rr(), 16'h3);
		setT(8'h02);
		chk(rr() & 16'h2, 16'h0);
	endtask

	task automatic t_three_wire();
		runWiringMode <= WIRE_THREE;
		fc3 <= FN_EXT_FAULT;
		setT(8'h02);
		chk(rr(), 16'h0);
		setT(8'h03);
		setT(8'h02);
		chk(rr(), 16'h2);
		setT(8'h06);
		chk(rr(), 16'h3);
		chk(faultTripped, 16'h0);
		setT(8'h04);
		setT(8'h06);
		chk(rr() & 16'h2, 16'h0);
		setT(8'h00);
		fc3 <= FN_OFF;
	endtask

	task automatic t_fault();
		runWiringMode <= WIRE_TWO_DIR;
		fc4 <= FN_EXT_FAULT;
		fc5 <= FN_FAULT_RESET;
		setT(8'h21);
		chk(rr(), 16'h2);
		chk(faultTripped, 16'h0);
		setT(8'h09);
		chk(faultTripped, 16'h1);
		chk(rr(), 16'h0);
		chk(runState.driveOn, 16'h0);
		setT(8'h01);
		chk(faultTripped, 16'h1);
		// reset is pulsed, never held
		setT(8'h11);
		setT(8'h01);
		chk(faultTripped, 16'h0);
		chk(rr(), 16'h2);
		chk(runState.driveOn, 16'h1);
		fc7 <= FN_COAST;
		setT(8'h41);
		chk(coastStop, 16'h1);
		chk(rr(), 16'h0);
		setT(8'h00);
		chk(coastStop, 16'h0);
		fc4 <= FN_OFF;
		fc5 <= FN_OFF;
	endtask

	task automatic t_stage();
		logic [3:0] pat [5];
		ditd_func_t code [3];
		logic [15:0] src [3];
		pat = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
		code = '{FN_FORCE_AI1, FN_JOG, FN_AUTO};
		src = '{16'h04, 16'h08, 16'h10};
		// stage indexes 1, 2, 4, 8 and 15, each stage code on one terminal only
		fc3 <= FN_STAGE0;
		fc4 <= FN_STAGE1;
		fc5 <= FN_STAGE2;
		fc6 <= FN_STAGE3;
		for (int i = 0; i < 5; i++) begin
			setT({2'b00, pat[i], 2'b00});
			chk(stageIndex, pat[i]);
			chk(speedSource, 16'h02);
		end
		// each higher source overrides the stage selection
		for (int i = 0; i < 3; i++) begin
			fc8 <= code[i];
			setT(8'h84);
			chk(speedSource, src[i]);
			setT(8'h00);
		end
		// pause and pid are plain levels, the stage stays in charge
		fc8 <= FN_AUTO_PAUSE;
		setT(8'h84);
		chk(auxFunc, 16'h08);
		chk(speedSource, 16'h02);
		fc8 <= FN_PID;
		setT(8'h84);
		chk(auxFunc, 16'h04);
		setT(8'h00);
		fc8 <= FN_SERIAL;
		setT(8'h80);
		chk(auxFunc.serialBus, 16'h1);
		fc8 <= FN_OFF;
		fc3 <= FN_SERIAL;
		setT(8'h04);
		chk(auxFunc.serialBus, 16'h0);
		setT(8'h00);
	endtask

	// min ramp 20 s: one step per 400 clocks with the short scan step
	task automatic t_ramp();
		fc3 <= FN_SPEED_UP;
		fc4 <= FN_SPEED_DOWN;
		setT(8'h04);
		cyc(1000);
		chk(masterSpeed, 16'h0);
		freqSrc <= 4'h8;
		cyc(1000);
		chk(masterSpeed >= 16'd1 && masterSpeed <= 16'd3, 16'h1);
		setT(8'h08);
		cyc(1600);
		chk(masterSpeed, 16'h0);
	endtask

	// ============================================================
	// main sequence
	initial begin
		fail_count = 0;
		checked = 0;
		nrst = 1'b0;
		scanPeriodLoad = 1'b0;
		inputScanPeriod = 11'd10;
		runWiringMode = 2'h0;
		{fc3, fc4, fc5, fc6, fc7, fc8} = 24'h0;
		freqSrc = 4'h0;
		accelTime = 16'h0;
		decelTime = 16'h0;
		termCmd = 8'h00;
		bounceEn = 1'b1;
		cyc(20);
		nrst <= 1'b1;
		cyc(1);
		t_scan();
		t_two_wire();
		t_three_wire();
		t_fault();
		t_stage();
		t_ramp();
		give_verdict();
	end

	// watchdog far beyond the roughly 6700 clocks of the scenarios
	initial begin
		cyc(40000);
		fail_count++;
		give_verdict();
	end
endmodule

`default_nettype wire
